// >>> hw/disk_file_attachment_control.sv
// channel and disk drive attachment control driven by the microprogram
//
// Operation
// - set error bit 4 on parity mismatch without bus-out parity error; stop machine.
// - halt I/O sets error bit 7; short busy sets bit 3 and also sets bit 7.
// - microword address is 12 bits in two halves; top bit unused.
// - channel tag has 8 latches: write, op-in reset, read, status-in.
// - tag bit 3 raises request-in only while suppress-out is down.
// - tag bit 4 lets gated attention raise request-in unless suppressed.
// - tag bit 6 raises request-in regardless of suppress-out.
// - tag bit 7 drives address-in and conditions operational-in.
// - five extra latches steer channel service responses.
// - nine gates pass bus-out with parity onto the A bus.
// - nine bus-in gates drive write data register to channel.
// - drive tag bit 7 selects drive interface and marks file type.
// - three-bit unit field decodes one-hot into unit register.
// - drive tag latches load data value only where D-bus bit is one.
// - control bit 2 with tag bits 0..3 selects drive operations.
// - index during write with control 140 clears only write gate.
// - unit select reaches drives only while drive tag bit 7 set.
// - seek-complete attentions gate onto A bus and OR into interrupt.
// - poll enable and channel free let attention raise request-in.
// - drive status gated onto A bus at fixed bit positions.
// - file operable formed from status drives interface status bit 3.
`timescale 1ns/10ps
module disk_file_attachment_control
	import dfa_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// microprogram control
	input  wire logic [0:7]        dBus,
	input  wire logic              latchDataValue,
	input  wire logic              ldChanTag,
	input  wire logic              ldDriveTag,
	input  wire logic              ldDriveCtl,
	input  wire logic              ldUnit,
	input  wire logic [2:0]        unitField,
	input  wire logic              ldWriteData,
	input  wire logic              writeDataParity,
	input  wire logic              ldAddrHi,
	input  wire logic              ldAddrLo,
	input  wire asel_e             aSel,
	input  wire logic              aluBypass,
	input  wire logic              aRegParity,
	input  wire logic              aluParity,
	input  wire logic              haltIo,
	input  wire logic              shortBusy,
	input  wire logic              writeDataErr,
	input  wire logic              clrError,
	input  wire logic              serviceReq,
	// channel and drive pins
	input  wire chan_pins_s        chanIn,
	input  wire drive_pins_s       drvIn,
	// channel side
	output chan_out_s              chanOut,
	// drive side
	output drive_out_s             drvOut,
	output logic [0:7]             driveTag,
	output logic [0:7]             driveCtl,
	// internal views
	output logic [0:8]             aBus,
	output logic [0:7]             interfaceStatus,
	output logic [0:7]             errorLatches,
	output logic                   dataCheck,
	output logic                   machineStop,
	output logic [MA_WIDTH-1:0]    microAddr,
	output logic [0:7]             chanTag
);

	typedef struct packed {
		chan_pins_s          chS1;
		chan_pins_s          chS2;
		drive_pins_s         drS1;
		drive_pins_s         drS2;
		logic                idxPrev;
		logic                svcOutPrev;
		logic [0:7]          unitReg;
		logic [0:8]          writeData;
		logic [MA_WIDTH-1:0] microAddr;
		logic [0:7]          err;
		logic                xfer1;
		logic                xfer2;
		logic                svcReq;
		logic                steerA;
		logic                dataCheck;
		chan_out_s           chanOut;
		drive_out_s          drvOut;
		logic [0:8]          aBus;
		logic [0:7]          ifStatus;
	} state_s;

	state_s r_r;
	state_s r_nxt;

	logic [0:7] ctlClr;
	logic       idxRise;

	function automatic logic oddPar(input logic [0:7] v);
		oddPar = ~^v;
	endfunction

	function automatic logic [0:7] oneHot(input logic [2:0] f);
		logic [0:7] v;
		v = 8'h00;
		v[f] = 1'b1;
		oneHot = v;
	endfunction

	// the three latch registers share one per-bit load rule
	polarity_hold_reg uChanTag (
		.clk       (clk),
		.rst       (rst),
		.load      (ldChanTag),
		.ctlMask   (dBus),
		.dataValue (latchDataValue),
		.clrMask   (REG8_RST),
		.q         (chanTag)
	);

	polarity_hold_reg uDriveTag (
		.clk       (clk),
		.rst       (rst),
		.load      (ldDriveTag),
		.ctlMask   (dBus),
		.dataValue (latchDataValue),
		.clrMask   (REG8_RST),
		.q         (driveTag)
	);

	polarity_hold_reg uDriveCtl (
		.clk       (clk),
		.rst       (rst),
		.load      (ldDriveCtl),
		.ctlMask   (dBus),
		.dataValue (latchDataValue),
		.clrMask   (ctlClr),
		.q         (driveCtl)
	);

	assign idxRise = r_r.drS2.index & ~r_r.idxPrev;

	// index under write drops only the write gate latch
	always_comb begin
		ctlClr = REG8_RST;
		if (idxRise && driveCtl == FC_WRITE_ERASE && driveTag[FT_CTL_TAG]) begin
			ctlClr[FC_WRITE] = 1'b1;
		end
	end

	always_comb begin
		logic [0:7] errSet;
		logic [0:7] errClr;
		logic [0:7] fs;
		logic       boPerr;
		logic       attnAny;
		logic       sup;
		logic       svcOutRise;
		errSet = 8'h00;
		errClr = 8'h00;
		fs = 8'h00;
		boPerr = 1'b0;
		attnAny = 1'b0;
		sup = 1'b0;
		svcOutRise = 1'b0;
		r_nxt = r_r;

		// synchronisers: stage one feeds stage two only
		r_nxt.chS1 = chanIn;
		r_nxt.chS2 = r_r.chS1;
		r_nxt.drS1 = drvIn;
		r_nxt.drS2 = r_r.drS1;
		r_nxt.idxPrev = r_r.drS2.index;
		r_nxt.svcOutPrev = r_r.chS2.serviceOut;

		if (ldUnit) begin
			r_nxt.unitReg = oneHot(unitField);
		end
		if (ldWriteData) begin
			r_nxt.writeData = {dBus, writeDataParity};
		end
		// high half has only five live bits, the 2K store needs no more
		if (ldAddrHi) begin
			r_nxt.microAddr[MA_WIDTH-1:MA_HALF] = {1'b0, dBus[3:7]};
		end
		if (ldAddrLo) begin
			r_nxt.microAddr[MA_HALF-1:0] = dBus[2:7];
		end

		// errors: hardware set wins over a clear in the same cycle
		boPerr = (aSel == ASEL_BUSOUT) &&
			(oddPar(r_r.chS2.busOut[0:7]) != r_r.chS2.busOut[8]);
		errSet[ER_WR_DATA] = writeDataErr;
		errSet[ER_BO_PAR] = boPerr;
		errSet[ER_DATA_CHK] = aluBypass && (aRegParity != aluParity)
			&& !boPerr && !r_r.err[ER_BO_PAR];
		errSet[ER_HALT] = haltIo | shortBusy;
		errSet[ER_SHORT_BUSY] = shortBusy;
		if (clrError) begin
			errClr = dBus;
		end
		if (chanTag[CT_OPIN_RS]) begin
			errClr[ER_WR_DATA] = 1'b1;
			errClr[ER_BO_PAR] = 1'b1;
		end
		r_nxt.err = (r_r.err & ~errClr) | errSet;
		// address-out is only assembled here, never held
		r_nxt.err[ER_ADDR_OUT] = r_r.chS2.addressOut;
		r_nxt.dataCheck = r_nxt.err[ER_WR_DATA] | r_nxt.err[ER_BO_PAR]
			| r_nxt.err[ER_DATA_CHK];

		// channel tag lines
		sup = r_r.chS2.suppressOut;
		attnAny = |r_r.drS2.seekDone;
		r_nxt.chanOut.attnInterrupt = attnAny;
		r_nxt.chanOut.addressIn = chanTag[CT_ADDR];
		r_nxt.chanOut.statusIn = chanTag[CT_STATUS];
		if (chanTag[CT_ADDR]) begin
			r_nxt.chanOut.opIn = 1'b1;
		end else if (chanTag[CT_OPIN_RS]) begin
			r_nxt.chanOut.opIn = 1'b0;
		end
		r_nxt.chanOut.requestIn = (chanTag[CT_QUEUED] & ~sup)
			| (chanTag[CT_POLL] & attnAny & ~sup & ~r_r.chS2.selOther)
			| chanTag[CT_DEV_END];
		r_nxt.chanOut.busIn = r_r.writeData;

		// service controls
		r_nxt.xfer1 = chanTag[CT_WRITE];
		r_nxt.xfer2 = chanTag[CT_READ];
		svcOutRise = r_r.chS2.serviceOut & ~r_r.svcOutPrev;
		if (r_r.svcReq && (r_r.xfer1 || r_r.xfer2) && !r_r.chanOut.serviceIn) begin
			r_nxt.chanOut.serviceIn = 1'b1;
			r_nxt.svcReq = 1'b0;
		end
		if (svcOutRise) begin
			r_nxt.chanOut.serviceIn = 1'b0;
			r_nxt.steerA = ~r_r.steerA;
		end
		if (serviceReq) begin
			r_nxt.svcReq = 1'b1;
		end

		// drive side
		r_nxt.drvOut.unitSelect = driveTag[FT_SELECT] ? r_r.unitReg : REG8_RST;
		r_nxt.drvOut.returnZero = driveCtl[FC_CTL] & driveTag[FT_CTL_TAG];
		r_nxt.drvOut.loadCyl = driveCtl[FC_CTL] & driveTag[FT_LD_CYL];
		r_nxt.drvOut.headSelect = driveCtl[FC_CTL] & driveTag[FT_HEAD];
		r_nxt.drvOut.loadDiff = driveCtl[FC_CTL] & driveTag[FT_DIFF];
		r_nxt.drvOut.diffValue = ~driveCtl;

		// drive status, only from a selected drive
		if (driveTag[FT_SELECT]) begin
			fs[FS_READY] = r_r.drS2.ready;
			fs[FS_ONLINE] = r_r.drS2.onLine;
			fs[FS_UNSAFE] = r_r.drS2.unsafe;
			fs[FS_STRIP] = r_r.drS2.stripReady;
			fs[FS_EOC] = r_r.drS2.endOfCyl;
			fs[FS_SEEK_INC] = r_r.drS2.seekIncomplete;
		end
		r_nxt.ifStatus = REG8_RST;
		r_nxt.ifStatus[IS_OPERABLE] = fs[FS_READY] & fs[FS_ONLINE] & ~fs[FS_UNSAFE]
			& ~fs[FS_EOC] & ~fs[FS_SEEK_INC];

		case (aSel)
			ASEL_BUSOUT: r_nxt.aBus = r_r.chS2.busOut;
			ASEL_SEEK:   r_nxt.aBus = {r_r.drS2.seekDone, oddPar(r_r.drS2.seekDone)};
			ASEL_STATUS: r_nxt.aBus = {fs, oddPar(fs)};
			ASEL_UNIT:   r_nxt.aBus = {r_r.unitReg, oddPar(r_r.unitReg)};
			ASEL_ERROR:  r_nxt.aBus = {r_r.err, oddPar(r_r.err)};
			default:     r_nxt.aBus = REG9_RST;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign chanOut = r_r.chanOut;
	assign drvOut = r_r.drvOut;
	assign aBus = r_r.aBus;
	assign interfaceStatus = r_r.ifStatus;
	assign errorLatches = r_r.err;
	assign dataCheck = r_r.dataCheck;
	assign machineStop = r_r.err[ER_DATA_CHK];
	assign microAddr = r_r.microAddr;

	a_data_check: assert property (@(posedge clk) disable iff (rst)
		aluBypass && aRegParity != aluParity && aSel != ASEL_BUSOUT
		&& !errorLatches[ER_BO_PAR] |=> machineStop && dataCheck)
		else $error("parity mismatch did not stop machine");
	a_halt_sets: assert property (@(posedge clk) disable iff (rst)
		haltIo |=> errorLatches[ER_HALT])
		else $error("halt did not set error bit 7");
	a_addr_msb: assert property (@(posedge clk) disable iff (rst)
		ldAddrHi |=> microAddr[MA_WIDTH-1] == 1'b0 && microAddr[10:6] == $past(dBus[3:7]))
		else $error("microword high half wrong");
	a_queued_supp: assert property (@(posedge clk) disable iff (rst)
		chanTag[CT_QUEUED] && !chanTag[CT_POLL] && !chanTag[CT_DEV_END]
		&& r_r.chS2.suppressOut |=> !chanOut.requestIn)
		else $error("queued request ignored suppress-out");
	a_dev_end_req: assert property (@(posedge clk) disable iff (rst)
		chanTag[CT_DEV_END] |=> chanOut.requestIn)
		else $error("device end poll was suppressed");
	a_addr_in: assert property (@(posedge clk) disable iff (rst)
		chanTag[CT_ADDR] |=> chanOut.addressIn && chanOut.opIn)
		else $error("address-in or op-in missing");
	a_unit_decode: assert property (@(posedge clk) disable iff (rst)
		ldUnit ##1 (driveTag[FT_SELECT] && !ldUnit) |=> drvOut.unitSelect == oneHot($past(unitField, 2)))
		else $error("unit select not one-hot of field");
	a_unit_gate: assert property (@(posedge clk) disable iff (rst)
		!driveTag[FT_SELECT] |=> drvOut.unitSelect == REG8_RST)
		else $error("unit select passed without drive tag bit 7");
	a_write_drop: assert property (@(posedge clk) disable iff (rst)
		ctlClr[FC_WRITE] && !ldDriveCtl |=> !driveCtl[FC_WRITE]
		&& driveCtl[0:3] == $past(driveCtl[0:3]))
		else $error("index did not drop only write gate");
	a_operable: assert property (@(posedge clk) disable iff (rst)
		interfaceStatus[IS_OPERABLE] |-> !$past(r_r.drS2.unsafe) && $past(r_r.drS2.ready))
		else $error("operable with bad drive status");

endmodule // disk_file_attachment_control

// >>> hw/dfa_pkg.sv
// shared constants and types for the disk file attachment control block
package dfa_pkg;

	// bit positions use bit 0 as the most significant bit, weight 128
	localparam int CT_WRITE   = 0;
	localparam int CT_OPIN_RS = 1;
	localparam int CT_READ    = 2;
	localparam int CT_QUEUED  = 3;
	localparam int CT_POLL    = 4;
	localparam int CT_STATUS  = 5;
	localparam int CT_DEV_END = 6;
	localparam int CT_ADDR    = 7;

	localparam int FT_CTL_TAG = 0;
	localparam int FT_LD_CYL  = 1;
	localparam int FT_HEAD    = 2;
	localparam int FT_DIFF    = 3;
	localparam int FT_SELECT  = 7;

	localparam int FC_CTL     = 2;
	localparam int FC_WRITE   = 4;
	localparam logic [0:7] FC_WRITE_ERASE = 8'h8C;

	localparam int ER_WR_DATA = 0;
	localparam int ER_ADDR_OUT = 1;
	localparam int ER_BO_PAR  = 2;
	localparam int ER_SHORT_BUSY = 3;
	localparam int ER_DATA_CHK = 4;
	localparam int ER_HALT    = 7;

	localparam int FS_READY   = 0;
	localparam int FS_ONLINE  = 1;
	localparam int FS_UNSAFE  = 2;
	localparam int FS_STRIP   = 4;
	localparam int FS_EOC     = 5;
	localparam int FS_SEEK_INC = 7;
	localparam int IS_OPERABLE = 3;

	localparam int MA_WIDTH   = 12;
	localparam int MA_HALF    = 6;

	localparam logic [0:7] REG8_RST = 8'h00;
	localparam logic [0:8] REG9_RST = 9'h000;
	localparam logic [MA_WIDTH-1:0] MA_RST = 12'h000;

	typedef enum logic [2:0] {
		ASEL_NONE   = 3'b000,
		ASEL_BUSOUT = 3'b001,
		ASEL_SEEK   = 3'b010,
		ASEL_STATUS = 3'b011,
		ASEL_UNIT   = 3'b100,
		ASEL_ERROR  = 3'b101
	} asel_e;

	typedef struct packed {
		logic       suppressOut;
		logic       selOther;
		logic       serviceOut;
		logic       addressOut;
		logic [0:8] busOut;
	} chan_pins_s;

	typedef struct packed {
		logic [0:7] seekDone;
		logic       ready;
		logic       onLine;
		logic       unsafe;
		logic       stripReady;
		logic       endOfCyl;
		logic       seekIncomplete;
		logic       index;
	} drive_pins_s;

	typedef struct packed {
		logic       addressIn;
		logic       statusIn;
		logic       opIn;
		logic       requestIn;
		logic       serviceIn;
		logic       attnInterrupt;
		logic [0:8] busIn;
	} chan_out_s;

	typedef struct packed {
		logic [0:7] unitSelect;
		logic       returnZero;
		logic       loadCyl;
		logic       headSelect;
		logic       loadDiff;
		logic [0:7] diffValue;
	} drive_out_s;

	typedef struct packed {
		logic [0:7] q;
	} hold_s;

endpackage

// >>> hw/polarity_hold_reg.sv
// eight polarity-hold latches loaded per bit under a control mask
`timescale 1ns/10ps
module polarity_hold_reg
	import dfa_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// load path
	input  wire logic       load,
	input  wire logic [0:7] ctlMask,
	input  wire logic       dataValue,
	input  wire logic [0:7] clrMask,
	// latch contents
	output logic      [0:7] q
);

	hold_s r_r;
	hold_s r_nxt;

	always_comb begin
		r_nxt = r_r;
		r_nxt.q = r_r.q & ~clrMask;
		// only masked bits take the shared data value, the rest hold
		if (load) begin
			r_nxt.q = (r_nxt.q & ~ctlMask) | (ctlMask & {8{dataValue}});
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_r <= '{q: REG8_RST};
		end else begin
			r_r <= r_nxt;
		end
	end

	assign q = r_r.q;

endmodule // polarity_hold_reg

// >>> sim/drive_model.sv
// behavioural disk drive string facing the drive interface
`timescale 1ns/10ps
module drive_model
	import dfa_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// commands from the attachment
	input  wire drive_out_s cmd,
	// scenario controls
	input  wire logic [0:3] cond,
	input  wire logic       strip,
	input  wire logic       step,
	input  wire logic       idx,
	input  wire logic [0:7] attn,
	// status back to the attachment
	output drive_pins_s     pins
);
	logic [3:0] headAddr;
	logic       eocHeld;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			headAddr <= 4'h0;
			eocHeld  <= 1'b0;
		end else if (cmd.returnZero) begin
			headAddr <= 4'h0;
			eocHeld  <= 1'b0;
		end else if (step) begin
			if (headAddr == 4'h9) begin
				eocHeld <= 1'b1;
			end else begin
				headAddr <= headAddr + 4'h1;
			end
		end
	end

	// unselected status lines are terminated and read low
	always_comb begin
		pins          = '0;
		pins.seekDone = attn;
		pins.index    = idx;
		if (|cmd.unitSelect) begin
			{pins.ready, pins.onLine, pins.unsafe, pins.seekIncomplete} = cond;
			pins.stripReady = strip;
			pins.endOfCyl   = eocHeld;
		end
	end
endmodule // drive_model

// >>> sim/testbench.sv
// self-checking bench for the disk file attachment control block
`timescale 1ns/10ps
module testbench;
	import dfa_pkg::*;
	typedef struct {int due; int kind; logic [15:0] exp;} note_s;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [0:7]  dBus = 8'h00;
	logic        dv = 1'b0;
	logic [12:0] stb = 13'h0000;
	logic [2:0]  unitField = 3'h0;
	asel_e       aSel = ASEL_NONE;
	chan_pins_s  chanIn = 13'h0001;
	drive_pins_s drvIn;
	chan_out_s   chanOut;
	drive_out_s  drvOut;
	logic [0:7]  driveTag, driveCtl, interfaceStatus, errorLatches, chanTag;
	logic [0:8]  aBus;
	logic        dataCheck, machineStop;
	logic [11:0] microAddr;
	logic [0:3]  cond = 4'h0;
	logic        strip = 1'b0, step = 1'b0, idx = 1'b0;
	logic [0:7]  attn = 8'h00;
	logic [15:0] rnd = 16'hAC9D;
	logic [0:7]  ft = 8'h00, fc = 8'h00, ct = 8'h00, sb, at;
	logic        opE = 1'b0, rq;
	note_s       notes[$];
	int          cyc = 0, miscompares = 0, checks_done = 0;
	int          errKind[5] = '{7, 8, 12, 12, 10};
	logic [9:0]  errExp[5] = '{10'h004, 10'h044, 10'h000, 10'h023, 10'h202};

	disk_file_attachment_control i_dut (
		.clk(clk), .rst(rst), .dBus(dBus), .latchDataValue(dv),
		.ldDriveTag(stb[0]), .ldDriveCtl(stb[1]), .ldChanTag(stb[2]), .ldUnit(stb[3]),
		.unitField(unitField), .ldWriteData(stb[4]), .writeDataParity(dv),
		.ldAddrHi(stb[5]), .ldAddrLo(stb[6]), .aSel(aSel), .aluBypass(stb[12]),
		.aRegParity(dv), .aluParity(dBus[0]), .haltIo(stb[7]), .shortBusy(stb[8]),
		.writeDataErr(stb[10]), .clrError(stb[9]), .serviceReq(stb[11]),
		.chanIn(chanIn), .drvIn(drvIn), .chanOut(chanOut), .drvOut(drvOut),
		.driveTag(driveTag), .driveCtl(driveCtl), .aBus(aBus),
		.interfaceStatus(interfaceStatus), .errorLatches(errorLatches),
		.dataCheck(dataCheck), .machineStop(machineStop), .microAddr(microAddr),
		.chanTag(chanTag)
	);

	drive_model i_drive (
		.clk(clk), .rst(rst), .cmd(drvOut), .cond(cond), .strip(strip),
		.step(step), .idx(idx), .attn(attn), .pins(drvIn)
	);

	always #25 clk = ~clk;

	function automatic logic [15:0] lf(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [0:7] ph(input logic [0:7] o, input logic [0:7] m, input logic v);
		return v ? (o | m) : (o & ~m);
	endfunction

	function automatic logic [15:0] obs(input int k);
		case (k)
			0: return {8'h00, driveTag};
			1: return {8'h00, driveCtl};
			2: return {8'h00, chanTag};
			3: return {8'h00, drvOut.unitSelect};
			4: return {4'h0, drvOut.returnZero, drvOut.loadCyl, drvOut.headSelect,
				drvOut.loadDiff, drvOut.diffValue};
			5: return {7'h00, aBus};
			6: return {8'h00, interfaceStatus};
			7: return {6'h00, errorLatches, dataCheck, machineStop};
			8: return {10'h000, chanOut.addressIn, chanOut.statusIn, chanOut.opIn,
				chanOut.requestIn, chanOut.serviceIn, chanOut.attnInterrupt};
			9: return {7'h00, chanOut.busIn};
			default: return {4'h0, microAddr};
		endcase
	endfunction

	// one strobe per call; the idle edge after it keeps strobes from merging
	task automatic ld(input int w, input logic [0:7] m, input logic v = 1'b1);
		@(posedge clk);
		dBus <= m;
		dv <= v;
		unitField <= m[5:7];
		stb <= 13'h0001 << w;
		@(posedge clk);
		stb <= 13'h0000;
	endtask

	task automatic note(input int k, input logic [15:0] e, input int d);
		notes.push_back('{cyc + d, k, e});
	endtask

	task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// results are taken off the queue once settled, half a cycle after the edge
	always @(negedge clk) begin
		cyc++;
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			compare(obs(notes[0].kind), notes[0].exp);
			void'(notes.pop_front());
		end
		if (cyc == 4000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < 11; k++) begin
			if (!(k inside {4, 5, 6})) note(k, 16'h0000, 1);
		end
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			rnd = lf(rnd);
			if (i % 2 == 1) begin
				fc = ph(fc, rnd[7:0], rnd[8]);
				ld(1, rnd[7:0], rnd[8]);
				note(1, fc, 1);
			end else begin
				ft = ph(ft, rnd[7:0], rnd[8]);
				ld(0, rnd[7:0], rnd[8]);
				note(0, ft, 1);
			end
		end
		ld(0, 8'hFF, 1'b0);
		ld(1, 8'hFF, 1'b0);
		$display("test latch loads done");
		ld(3, 8'h00);
		note(3, 16'h0000, 2);
		ld(0, 8'h01);
		for (int u = 0; u < 8; u++) begin
			ld(3, 8'(u));
			note(3, 16'h0080 >> u, 2);
		end
		$display("test unit select done");
		aSel <= ASEL_UNIT;
		note(5, 16'h0002, 3);
		ld(1, 8'h20);
		for (int t = 0; t < 4; t++) begin
			ld(0, 8'h80 >> t);
			note(4, {4'h8 >> t, 8'hDF}, 2);
			ld(0, 8'h80 >> t, 1'b0);
		end
		$display("test drive operations done");
		ld(1, 8'hFF, 1'b0);
		ld(1, 8'h8C);
		ld(0, 8'h80);
		@(posedge clk);
		idx <= 1'b1;
		repeat (2) @(posedge clk);
		idx <= 1'b0;
		note(0, 16'h0081, 1);
		note(1, 16'h0084, 6);
		repeat (6) @(posedge clk);
		ld(0, 8'h80, 1'b0);
		ld(1, 8'hFF, 1'b0);
		$display("test index drop done");
		aSel <= ASEL_STATUS;
		for (int i = 0; i < 9; i++) begin
			rnd = lf(rnd);
			if (i == 0 || i == 8) rnd[3:0] = 4'hC;
			// ten steps: nine reach the last head, the tenth overruns it
			if (i == 8) repeat (10) begin
				@(posedge clk);
				step <= 1'b1;
				@(posedge clk);
				step <= 1'b0;
			end
			@(posedge clk);
			cond <= rnd[3:0];
			strip <= rnd[4];
			sb = {rnd[3], rnd[2], rnd[1], 1'b0, rnd[4], i == 8, 1'b0, rnd[0]};
			note(5, {sb, ~^sb}, 6);
			note(6, (rnd[3:0] == 4'hC && i < 8) ? 16'h0010 : 16'h0000, 6);
			repeat (6) @(posedge clk);
		end
		$display("test drive status done");
		aSel <= ASEL_SEEK;
		for (int i = 0; i < 16; i++) begin
			rnd = lf(rnd);
			at = rnd[11] ? rnd[15:8] : 8'h00;
			@(posedge clk);
			chanIn.suppressOut <= rnd[9];
			chanIn.selOther <= rnd[10];
			attn <= at;
			ct = ph(ct, rnd[7:0], rnd[12]);
			ld(2, rnd[7:0], rnd[12]);
			opE = ct[7] | (opE & ~ct[1]);
			rq = (ct[3] & ~rnd[9]) | (ct[4] & (|at) & ~rnd[9] & ~rnd[10]) | ct[6];
			note(2, ct, 1);
			note(8, {ct[7], ct[5], opE, rq, 1'b0, |at}, 6);
			note(5, {at, ~^at}, 6);
			repeat (6) @(posedge clk);
		end
		// quiet attentions so the service check sees no interrupt
		attn <= 8'h00;
		$display("test channel tags done");
		ld(2, 8'hFF, 1'b0);
		ld(2, 8'h80);
		ld(11, 8'h00);
		note(8, {3'b000, opE, 3'b010}, 3);
		@(posedge clk);
		chanIn.serviceOut <= 1'b1;
		note(8, {3'b000, opE, 3'b000}, 8);
		repeat (8) @(posedge clk);
		chanIn.serviceOut <= 1'b0;
		$display("test service done");
		aSel <= ASEL_BUSOUT;
		for (int i = 0; i < 4; i++) begin
			rnd = lf(rnd);
			@(posedge clk);
			chanIn.busOut <= {rnd[7:0], ~^rnd[7:0]};
			ld(4, rnd[15:8], ^rnd[15:8]);
			note(9, {rnd[15:8], ^rnd[15:8]}, 3);
			note(5, {rnd[7:0], ~^rnd[7:0]}, 5);
			repeat (5) @(posedge clk);
		end
		aSel <= ASEL_NONE;
		$display("test bus gates done");
		ld(5, 8'hFF);
		note(10, 16'h07C0, 1);
		ld(6, 8'hFF);
		note(10, 16'h07FF, 1);
		ld(5, 8'h2A);
		note(10, 16'h02BF, 1);
		$display("test micro address done");
		// a stop only raises its flag here, so later cases still run
		for (int i = 0; i < 5; i++) begin
			ld(9, 8'hFF);
			ld(errKind[i], (i == 2) ? 8'h80 : 8'h00);
			note(7, errExp[i], 2);
			repeat (2) @(posedge clk);
		end
		aSel <= ASEL_ERROR;
		note(5, 16'h0100, 3);
		$display("test error latches done");
		repeat (10) @(posedge clk);
		wrap_up();
	end
endmodule // testbench
